// ==== hdl/ixt_pkg.sv ====
// Package: register map, fields and reset values of the identity and test register group
package ixt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IXT_MAKER_IDENTITY_ADDR = 8'h3e;
  localparam logic [7:0] IXT_VERSION_STEPPING_ADDR = 8'h3f;
  localparam logic [7:0] IXT_TEST_CONTROL_ADDR = 8'h6f;
  localparam logic [7:0] IXT_VENDOR_LO_ADDR = 8'h70;
  localparam logic [7:0] IXT_VENDOR_HI_ADDR = 8'h7f;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int IXT_XOR_TREE_ENABLE_BIT = 0;
  localparam int IXT_STEPPING_LSB = 0;
  localparam int IXT_BASE_DEVICE_LSB = 4;
  localparam logic [7:0] IXT_TEST_CONTROL_RESET = 8'h00;
  localparam logic [7:0] IXT_ZERO_BYTE = 8'h00;

  // Arbitrary identity values, not tied to any real part
  localparam logic [7:0] IXT_MAKER_IDENTITY_DEFAULT = 8'h5a;
  localparam logic [3:0] IXT_BASE_DEVICE_DEFAULT = 4'h3;
  localparam logic [3:0] IXT_STEPPING_DEFAULT = 4'h1;

  // Width of the non-serial pin group fed into the XOR tree
  localparam int IXT_TREE_WIDTH = 16;

  // ----------------------------------------------------------------
  // Register access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ixt_req_type;

endpackage : ixt_pkg

// ==== hdl/ixt_regs.sv ====
// Identity, version and XOR-tree test register group
// Summary of operation
// RULE1: Maker identity register is read-only; writes leave it unchanged.
// RULE2: Version register: low nibble stepping, high nibble base device; read-only.
// RULE3: Setting bit 0 of test register enters XOR-tree mode; register resets to zero.
// RULE4: XOR tree leaves out the serial data and clock pins.
// RULE5: With configuration lock set, test register writes are discarded.
// RULE6: Vendor range contents undefined; reads here return zero, writes ignored.
// RULE7: Test register bits 7 to 1 read zero; writes to them ignored.
`timescale 1ns/100ps
`default_nettype none

module ixt_regs
  import ixt_pkg::*;
#(
  parameter logic [7:0] MAKER_IDENTITY = IXT_MAKER_IDENTITY_DEFAULT,
  parameter logic [3:0] BASE_DEVICE = IXT_BASE_DEVICE_DEFAULT,
  parameter logic [3:0] STEPPING = IXT_STEPPING_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire ixt_req_type req,
  input wire logic config_lock,
  input wire logic [IXT_TREE_WIDTH-1:0] tree_pins,
  output logic [7:0] rdata,
  output logic xor_tree_enable,
  output logic xor_tree_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic hit_maker;
  wire logic hit_version;
  wire logic hit_test;
  wire logic test_wr;
  wire logic [7:0] version_word;
  wire logic [7:0] test_word;
  wire logic [7:0] rdata_d;
  wire logic tree_d;
  wire logic hit_vendor;
  wire logic hit_none;

  assign hit_maker = req.addr == IXT_MAKER_IDENTITY_ADDR;
  assign hit_version = req.addr == IXT_VERSION_STEPPING_ADDR;
  assign hit_test = req.addr == IXT_TEST_CONTROL_ADDR;
  // Lock gates the write strobe; the stored bit keeps its value
  assign test_wr = req.wr_en && hit_test && !config_lock; // RULE5
  assign version_word = {BASE_DEVICE, STEPPING}; // RULE2
  // Only the enable bit is stored, so the upper bits read zero
  assign test_word = {7'h00, xor_tree_enable}; // RULE7
  // Identity and version have no write path at all
  assign rdata_d = hit_maker ? MAKER_IDENTITY : // RULE1
                   hit_version ? version_word : // RULE2
                   hit_test ? test_word :
                   IXT_ZERO_BYTE; // RULE6
  // Serial pins are not part of tree_pins, keeping the bus usable in test
  assign tree_d = ^tree_pins; // RULE4
  // Vendor range and holes are only named for the checks below
  assign hit_vendor = req.addr >= IXT_VENDOR_LO_ADDR && req.addr <= IXT_VENDOR_HI_ADDR; // RULE6
  assign hit_none = !(hit_maker || hit_version || hit_test); // RULE6

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      xor_tree_enable <= IXT_TEST_CONTROL_RESET[IXT_XOR_TREE_ENABLE_BIT]; // RULE3
    end else if (test_wr) begin
      xor_tree_enable <= req.wdata[IXT_XOR_TREE_ENABLE_BIT]; // RULE3
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= IXT_ZERO_BYTE;
    end else if (req.rd_en) begin
      rdata <= rdata_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      xor_tree_out <= 1'b0;
    end else begin
      xor_tree_out <= xor_tree_enable ? tree_d : 1'b0; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TEST_WRITE_TAKES: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    test_wr |=> xor_tree_enable == $past(req.wdata[0]))
    else $error("test enable did not follow an unlocked write");
  AST_LOCK_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
    config_lock |=> $stable(xor_tree_enable))
    else $error("test enable changed while locked");
  AST_MAKER_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
    (req.rd_en && hit_maker) |=> rdata == MAKER_IDENTITY)
    else $error("maker identity read wrong");
  AST_VERSION_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
    (req.rd_en && hit_version) |=> rdata[7:4] == BASE_DEVICE && rdata[3:0] == STEPPING)
    else $error("version read wrong");
  AST_TEST_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
    (req.rd_en && hit_test) |=> rdata[7:1] == 7'h00 && rdata[0] == $past(xor_tree_enable))
    else $error("test register read wrong");
  AST_VENDOR_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
    (req.rd_en && req.addr >= IXT_VENDOR_LO_ADDR && req.addr <= IXT_VENDOR_HI_ADDR)
      |=> rdata == 8'h00)
    else $error("vendor range read not zero");
  AST_TREE_PARITY: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
    xor_tree_enable |=> xor_tree_out == $past(^tree_pins))
    else $error("xor tree output wrong");
  AST_TREE_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    !xor_tree_enable |=> !xor_tree_out)
    else $error("xor tree active while disabled");

  // ----------------------------------------------------------------
  // Reset and read path checks
  // ----------------------------------------------------------------
  AST_RESET_STATE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    $rose(rst_b)
      |-> rdata == IXT_ZERO_BYTE && !xor_tree_enable && !xor_tree_out)
    else $error("state after reset wrong");

  AST_RDATA_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
    !req.rd_en
      |=> $stable(rdata))
    else $error("read data moved without a read");

  AST_RDATA_ONLY_ON_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
    $changed(rdata)
      |-> $past(req.rd_en))
    else $error("read data changed with no read strobe");

  AST_UNMAPPED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
    (req.rd_en && hit_none)
      |=> rdata == IXT_ZERO_BYTE)
    else $error("unmapped read not zero");

  AST_WRITE_ALONE_NO_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
    (req.wr_en && !req.rd_en)
      |=> $stable(rdata))
    else $error("write disturbed read data");

  // ----------------------------------------------------------------
  // Test register checks
  // ----------------------------------------------------------------
  AST_ENABLE_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    !test_wr
      |=> $stable(xor_tree_enable))
    else $error("test enable moved without a write");

  AST_ENABLE_RISE_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    $rose(xor_tree_enable)
      |-> $past(test_wr) && $past(req.wdata[0]))
    else $error("test enable rose without a write of one");

  AST_ENABLE_FALL_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    $fell(xor_tree_enable)
      |-> $past(test_wr) && !$past(req.wdata[0]))
    else $error("test enable fell without a write of zero");

  AST_DISABLE_OUT_LOW: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    $fell(xor_tree_enable)
      |=> !xor_tree_out)
    else $error("xor tree output stayed after leaving test");

  AST_IDLE_NO_EFFECT: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
    (!req.wr_en && !req.rd_en)
      |=> $stable(xor_tree_enable) && $stable(rdata))
    else $error("idle bus changed register state");

  AST_MAKER_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
    (req.wr_en && hit_maker)
      |=> $stable(xor_tree_enable))
    else $error("identity write had an effect");

  AST_VERSION_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
    (req.wr_en && hit_version)
      |=> $stable(xor_tree_enable))
    else $error("version write had an effect");

  AST_VENDOR_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
    (req.wr_en && hit_vendor)
      |=> $stable(xor_tree_enable))
    else $error("vendor range write had an effect");

  AST_LOCKED_WRITE_DROPPED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
    (req.wr_en && hit_test && config_lock)
      |=> $stable(xor_tree_enable))
    else $error("locked test write took effect");

  AST_LOCK_GATES_STROBE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
    config_lock
      |-> !test_wr)
    else $error("test write strobe while locked");

  AST_RESERVED_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
    (test_wr && !req.wdata[0])
      |=> !xor_tree_enable)
    else $error("reserved bits changed test enable");

  AST_OUT_NEEDS_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
    xor_tree_out
      |-> $past(xor_tree_enable))
    else $error("xor tree output high outside test");

endmodule // ixt_regs

`default_nettype wire

// ==== sim/ixt_host.sv ====
// Host model issuing single-byte register accesses
`timescale 1ns/100ps
`default_nettype none
module ixt_host
  import ixt_pkg::*;
(
  input wire logic core_clk,
  output var ixt_req_type req
);
  initial req = '0;
  // Released fields flip so a stale value never reads as valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
    @(negedge core_clk);
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // ixt_host
`default_nettype wire

// ==== sim/ixt_regs_tb.sv ====
// Self-checking bench for the identity and test registers
`timescale 1ns/100ps
`default_nettype none
module ixt_regs_tb
  import ixt_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic config_lock = 1'b0;
  logic [IXT_TREE_WIDTH-1:0] tree_pins = 16'h0b03;
  ixt_req_type req;
  logic [7:0] rdata;
  logic xor_tree_enable, xor_tree_out;
  int bad_count = 0;
  int checks_done = 0;
  always #2.5 core_clk = ~core_clk;
  ixt_host i_host (.core_clk(core_clk), .req(req));
  ixt_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .config_lock(config_lock),
    .tree_pins(tree_pins), .rdata(rdata), .xor_tree_enable(xor_tree_enable),
    .xor_tree_out(xor_tree_out));
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] exp);
    i_host.access(1'b0, a, 8'h00);
    chk(n, rdata, exp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ident();
    i_host.access(1'b1, IXT_MAKER_IDENTITY_ADDR, 8'ha5);
    i_host.access(1'b1, IXT_VERSION_STEPPING_ADDR, 8'ha5);
    rd_chk("maker", IXT_MAKER_IDENTITY_ADDR, IXT_MAKER_IDENTITY_DEFAULT);
    rd_chk("ver", IXT_VERSION_STEPPING_ADDR, {IXT_BASE_DEVICE_DEFAULT, IXT_STEPPING_DEFAULT});
  endtask
  task automatic t_tree();
    rd_chk("test rst", IXT_TEST_CONTROL_ADDR, IXT_TEST_CONTROL_RESET);
    i_host.access(1'b1, IXT_TEST_CONTROL_ADDR, 8'hff);
    chk("en", {7'h00, xor_tree_enable}, 8'h01);
    @(negedge core_clk);
    chk("tree", {7'h00, xor_tree_out}, 8'h01);
    rd_chk("res", IXT_TEST_CONTROL_ADDR, 8'h01);
    tree_pins = 16'h8001;
    @(negedge core_clk);
    chk("tree", {7'h00, xor_tree_out}, 8'h00);
    config_lock = 1'b1;
    i_host.access(1'b1, IXT_TEST_CONTROL_ADDR, 8'h00);
    rd_chk("lock", IXT_TEST_CONTROL_ADDR, 8'h01);
    config_lock = 1'b0;
    i_host.access(1'b1, IXT_TEST_CONTROL_ADDR, 8'h00);
    chk("off", {7'h00, xor_tree_enable}, 8'h00);
  endtask
  // Undefined range; this design returns zero
  task automatic t_vendor();
    for (int i = 0; i < 16; i++) begin
      i_host.access(1'b1, IXT_VENDOR_LO_ADDR + 8'(i), 8'hff);
      rd_chk("vendor", IXT_VENDOR_LO_ADDR + 8'(i), IXT_ZERO_BYTE);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    t_ident();
    t_tree();
    t_vendor();
    test_done();
  end
  initial begin
    #5000;
    bad_count++;
    test_done();
  end
endmodule // ixt_regs_tb
`default_nettype wire
